//--- cfg_pkg.sv
package cfg_pkg;
  // hardware_configuration bit positions
  localparam int SW_RESET_TRIGGER_BIT = 0;
  localparam int SW_RESET_TIMEOUT_FLAG_BIT = 1;
  localparam int EXT_EN_BIT = 2;
  localparam int PHY_DET_BIT = 3;
  localparam int TX_SZ_LSB = 16;
  localparam int TX_SZ_W = 4;
  localparam logic [3:0] TX_SZ_RESET = 4'h5;
  localparam logic [3:0] TX_SZ_MIN = 4'h2;
  localparam logic [3:0] TX_SZ_MAX = 4'he;
  localparam logic EXT_EN_RESET = 1'h0;

  // buffer partitioning, in bytes
  localparam int BUF_BYTES = 16384;
  localparam int KBYTE_BYTES = 1024;
  localparam int TX_STAT_BYTES = 512;
  localparam int TX_STAT_WORDS = 128;
  localparam int RX_STAT_SHIFT = 4;
  localparam int WORD_BYTES = 4;
  localparam int RX_FULL_MARGIN_WORDS = 4;
  localparam int TX_STAGE_BYTES = 2048;
  localparam int RX_STAGE_BYTES = 128;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SW_RESET_TRIGGER_TIMEOUT_NS = 10000;
  localparam int SW_RESET_TRIGGER_TIMEOUT_CYC = SW_RESET_TRIGGER_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // device register port word selects
  localparam logic [1:0] LNK_HARDWARE_CONFIGURATION = 2'h0;
  localparam logic [1:0] LNK_DROP_CNT = 2'h1;

  // avalon word addresses of the controller
  localparam logic [1:0] AVS_HARDWARE_CONFIGURATION = 2'h0;
  localparam logic [1:0] AVS_DROP_CNT = 2'h1;
  localparam logic [1:0] AVS_STATUS = 2'h2;
  localparam int STAT_READ_DONE = 0;
  localparam int STAT_REFUSED = 1;
endpackage

//--- cfg_link_if.sv
interface cfg_link_if;
  // request from the controller
  logic req;
  logic wr;
  logic [1:0] addr;
  logic [31:0] wdata;
  // answer from the device
  logic [31:0] rdata;
  logic ack;

  modport dev (
    input req,
    input wr,
    input addr,
    input wdata,
    output rdata,
    output ack
  );

  modport ctl (
    output req,
    output wr,
    output addr,
    output wdata,
    input rdata,
    input ack
  );
endinterface

//--- fifo_partition_dev.sv

module stage_buf #(
  parameter int W = 33,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clr,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;

  wire push = in_valid & in_ready;
  wire load = (cnt_q != '0) & (~out_valid | out_ready);
  wire [CW-1:0] cnt_d = cnt_q + CW'(push) - CW'(load);

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (clr) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + AW'(1);
      end
      if (load) begin
        out_data <= mem_q[rd_q];
        rd_q <= rd_q + AW'(1);
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      cnt_q <= cnt_d;
      // registered so the filling side never sees a combinational ready
      in_ready <= cnt_d != CW'(DEPTH);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module fifo_partition_dev
  import cfg_pkg::*;
#(
  parameter int TX_STAGE_WORDS = TX_STAGE_BYTES / WORD_BYTES,
  parameter int RX_STAGE_WORDS = RX_STAGE_BYTES / WORD_BYTES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  cfg_link_if.dev lnk,
  // pins
  input wire logic mdio_in,
  input wire logic phy_rx_clk,
  input wire logic phy_tx_clk,
  // power state
  input wire logic pm_wake,
  // configuration outcome
  output logic ext_mii_enable,
  output logic int_phy_enable,
  output logic mac_reset,
  output logic system_control_status_regs_reset,
  output logic [14:0] tx_data_bytes,
  output logic [14:0] rx_data_bytes,
  output logic [14:0] rx_status_bytes,
  // error flags
  input wire logic tx_err_evt,
  input wire logic rx_err_evt,
  output logic tx_error_flag,
  output logic rx_error_flag,
  // tx data fifo to mac
  input wire logic txf_valid,
  input wire logic [31:0] txf_data,
  input wire logic txf_last,
  output logic txf_ready,
  output logic mac_tx_valid,
  output logic [31:0] mac_tx_data,
  output logic mac_tx_last,
  input wire logic mac_tx_ready,
  // mac to rx data fifo
  input wire logic mac_rx_valid,
  input wire logic [31:0] mac_rx_data,
  input wire logic mac_rx_last,
  output logic rxf_valid,
  output logic [31:0] rxf_data,
  output logic rxf_last,
  input wire logic [12:0] rxf_used_words,
  output logic rxf_full,
  output logic [15:0] drop_count
);
  typedef enum logic [0:0] {SR_IDLE, SR_WAIT} sr_state_type;

  sr_state_type sr_q;
  logic mdio_s1_q, mdio_s2_q;
  logic rxc_s1_q, rxc_s2_q, rxc_s3_q;
  logic txc_s1_q, txc_s2_q, txc_s3_q;
  logic [1:0] strap_cnt_q;
  logic phy_det_q;
  logic ext_sel_q;
  logic [3:0] tx_sz_q;
  logic sr_to_q;
  logic read_seen_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [10:0] tmo_q;
  logic rx_seen_q, tx_seen_q;
  logic drop_q;
  logic sr_done;
  logic rx_in_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // register port decode

  wire take = lnk.req & ~ack_q;
  wire cfg_wr = take & lnk.wr & (lnk.addr == LNK_HARDWARE_CONFIGURATION) & read_seen_q;
  wire start_sr = cfg_wr & lnk.wdata[SW_RESET_TRIGGER_BIT] & (sr_q == SR_IDLE);
  wire [31:0] cfg_rd = {12'h0, tx_sz_q, 12'h0, phy_det_q, ext_sel_q, sr_to_q, (sr_q == SR_WAIT)};
  wire [31:0] rd_mux = (lnk.addr == LNK_HARDWARE_CONFIGURATION) ? cfg_rd :
                       (lnk.addr == LNK_DROP_CNT) ? {16'h0, drop_count} : 32'h0;

  assign lnk.ack = ack_q;
  assign lnk.rdata = rdata_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      read_seen_q <= 1'b0;
    end else begin
      ack_q <= take;
      if (take) begin
        rdata_q <= rd_mux;
      end
      if (take & ~lnk.wr) begin
        read_seen_q <= 1'b1;
      end else if (pm_wake) begin
        read_seen_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture and pin synchronisers

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mdio_s1_q <= 1'b0;
      mdio_s2_q <= 1'b0;
      rxc_s1_q <= 1'b0;
      rxc_s2_q <= 1'b0;
      rxc_s3_q <= 1'b0;
      txc_s1_q <= 1'b0;
      txc_s2_q <= 1'b0;
      txc_s3_q <= 1'b0;
      strap_cnt_q <= 2'h0;
      phy_det_q <= 1'b0;
    end else begin
      mdio_s1_q <= mdio_in;
      mdio_s2_q <= mdio_s1_q;
      rxc_s1_q <= phy_rx_clk;
      rxc_s2_q <= rxc_s1_q;
      rxc_s3_q <= rxc_s2_q;
      txc_s1_q <= phy_tx_clk;
      txc_s2_q <= txc_s1_q;
      txc_s3_q <= txc_s2_q;
      // sampled on the first three cycles after release, then frozen; read only by software
      if (strap_cnt_q != STRAP_SETTLE) begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
        phy_det_q <= mdio_s2_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // configuration fields and soft reset

  assign sr_done = (sr_q == SR_WAIT) & rx_seen_q & tx_seen_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sr_q <= SR_IDLE;
      ext_sel_q <= EXT_EN_RESET;
      tx_sz_q <= TX_SZ_RESET;
      sr_to_q <= 1'b0;
      tmo_q <= 11'h0;
      rx_seen_q <= 1'b0;
      tx_seen_q <= 1'b0;
      mac_reset <= 1'b0;
      system_control_status_regs_reset <= 1'b0;
    end else begin
      mac_reset <= sr_done;
      system_control_status_regs_reset <= sr_done;
      // port select and allocation survive a soft reset
      if (cfg_wr) begin
        ext_sel_q <= lnk.wdata[EXT_EN_BIT];
        tx_sz_q <= lnk.wdata[TX_SZ_LSB +: TX_SZ_W];
      end
      case (sr_q)
        SR_IDLE: begin
          if (start_sr) begin
            sr_q <= SR_WAIT;
            sr_to_q <= 1'b0;
            tmo_q <= 11'h0;
            rx_seen_q <= 1'b0;
            tx_seen_q <= 1'b0;
          end
        end
        SR_WAIT: begin
          // both phy clocks must be seen toggling before the reset lands
          if (rxc_s2_q ^ rxc_s3_q) begin
            rx_seen_q <= 1'b1;
          end
          if (txc_s2_q ^ txc_s3_q) begin
            tx_seen_q <= 1'b1;
          end
          tmo_q <= tmo_q + 11'h1;
          if (sr_done) begin
            sr_q <= SR_IDLE;
          end else if (tmo_q == 11'(SW_RESET_TRIGGER_TIMEOUT_CYC - 1)) begin
            sr_to_q <= 1'b1;
            sr_q <= SR_IDLE;
          end
        end
        default: sr_q <= SR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // partition sizes and routing

  wire [14:0] tx_total_b = 15'(int'(tx_sz_q) * KBYTE_BYTES);
  wire [14:0] rx_total_b = 15'(BUF_BYTES - int'(tx_total_b));
  wire [14:0] rx_stat_b = rx_total_b >> RX_STAT_SHIFT;
  wire [14:0] rx_data_words = rx_data_bytes >> 2;
  wire [14:0] rxf_fill = 15'(rxf_used_words) + 15'(RX_FULL_MARGIN_WORDS);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_mii_enable <= 1'b0;
      int_phy_enable <= 1'b1;
      tx_data_bytes <= 15'h0;
      rx_data_bytes <= 15'h0;
      rx_status_bytes <= 15'h0;
      rxf_full <= 1'b1;
      tx_error_flag <= 1'b0;
      rx_error_flag <= 1'b0;
    end else begin
      // only the port enables follow bit 2; mdio and clock muxes are elsewhere
      ext_mii_enable <= ext_sel_q;
      int_phy_enable <= ~ext_sel_q;
      tx_data_bytes <= tx_total_b - 15'(TX_STAT_BYTES);
      rx_data_bytes <= rx_total_b - rx_stat_b;
      rx_status_bytes <= rx_stat_b;
      // margin covers the lag of the used-word count
      rxf_full <= rxf_fill >= rx_data_words;
      // a new error beats the soft-reset clear
      if (tx_err_evt) begin
        tx_error_flag <= 1'b1;
      end else if (sr_done) begin
        tx_error_flag <= 1'b0;
      end
      if (rx_err_evt) begin
        rx_error_flag <= 1'b1;
      end else if (sr_done) begin
        rx_error_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // staging buffers, invisible to the host level counts

  stage_buf #(.W(33), .DEPTH(TX_STAGE_WORDS)) tx_stage (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clr(sr_done),
    .in_valid(txf_valid),
    .in_data({txf_last, txf_data}),
    .in_ready(txf_ready),
    .out_valid(mac_tx_valid),
    .out_data({mac_tx_last, mac_tx_data}),
    .out_ready(mac_tx_ready)
  );

  wire rx_overrun = mac_rx_valid & ~rx_in_ready & ~drop_q;

  stage_buf #(.W(33), .DEPTH(RX_STAGE_WORDS)) rx_stage (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .clr(sr_done),
    .in_valid(mac_rx_valid & ~drop_q),
    .in_data({mac_rx_last, mac_rx_data}),
    .in_ready(rx_in_ready),
    .out_valid(rxf_valid),
    .out_data({rxf_last, rxf_data}),
    .out_ready(~rxf_full)
  );

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      drop_q <= 1'b0;
      drop_count <= 16'h0;
    end else begin
      // words already staged from a cut frame stay; the rest is discarded
      if (rx_overrun & ~mac_rx_last) begin
        drop_q <= 1'b1;
      end else if (mac_rx_valid & mac_rx_last) begin
        drop_q <= 1'b0;
      end
      if (rx_overrun) begin
        drop_count <= drop_count + 16'h1;
      end
    end
  end
endmodule

//--- cfg_host_ctl.sv
module cfg_host_ctl
  import cfg_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // system state
  input wire logic phy_awake,
  input wire logic fifos_idle,
  // device register port
  cfg_link_if.ctl lnk
);
  typedef enum logic [1:0] {H_BOOT, H_IDLE, H_LINK, H_DONE} h_state_type;

  h_state_type st_q;
  logic boot_q;
  logic read_done_q;
  logic refused_q;
  logic [3:0] shadow_sz_q;
  logic req_q;
  logic wr_q;
  logic [1:0] addr_q;
  logic [31:0] wdata_q;

  assign lnk.req = req_q;
  assign lnk.wr = wr_q;
  assign lnk.addr = addr_q;
  assign lnk.wdata = wdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // request screening

  wire [3:0] new_sz = avs_writedata[TX_SZ_LSB +: TX_SZ_W];
  wire bad_code = (new_sz < TX_SZ_MIN) | (new_sz > TX_SZ_MAX);
  wire busy_change = (new_sz != shadow_sz_q) & ~fifos_idle;
  wire early_reset = avs_writedata[SW_RESET_TRIGGER_BIT] & ~phy_awake;
  wire cfg_write = avs_write & (avs_address == AVS_HARDWARE_CONFIGURATION);
  wire refuse = cfg_write & (bad_code | busy_change | early_reset);
  wire to_dev = (avs_address == AVS_HARDWARE_CONFIGURATION) | (avs_address == AVS_DROP_CNT);
  wire [31:0] status_word = {30'h0, refused_q, read_done_q};

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= H_BOOT;
      boot_q <= 1'b1;
      read_done_q <= 1'b0;
      refused_q <= 1'b0;
      shadow_sz_q <= TX_SZ_RESET;
      req_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= LNK_HARDWARE_CONFIGURATION;
      wdata_q <= 32'h0;
      avs_readdata <= 32'h0;
      avs_waitrequest <= 1'b1;
    end else begin
      case (st_q)
        H_BOOT: begin
          // first access to the device is a read, or its writes are dropped
          req_q <= 1'b1;
          wr_q <= 1'b0;
          addr_q <= LNK_HARDWARE_CONFIGURATION;
          st_q <= H_LINK;
        end
        H_IDLE: begin
          if (avs_read | avs_write) begin
            if (to_dev & ~refuse) begin
              req_q <= 1'b1;
              wr_q <= avs_write;
              addr_q <= avs_address;
              wdata_q <= avs_writedata;
              if (cfg_write) begin
                shadow_sz_q <= new_sz;
              end
              st_q <= H_LINK;
            end else begin
              avs_readdata <= (avs_read & (avs_address == AVS_STATUS)) ? status_word : 32'h0;
              if (refuse) begin
                refused_q <= 1'b1;
              end else if (avs_read & (avs_address == AVS_STATUS)) begin
                refused_q <= 1'b0;
              end
              avs_waitrequest <= 1'b0;
              st_q <= H_DONE;
            end
          end
        end
        H_LINK: begin
          if (lnk.ack) begin
            req_q <= 1'b0;
            if (boot_q) begin
              boot_q <= 1'b0;
              read_done_q <= 1'b1;
              shadow_sz_q <= lnk.rdata[TX_SZ_LSB +: TX_SZ_W];
              st_q <= H_IDLE;
            end else begin
              avs_readdata <= wr_q ? 32'h0 : lnk.rdata;
              avs_waitrequest <= 1'b0;
              st_q <= H_DONE;
            end
          end
        end
        H_DONE: begin
          avs_waitrequest <= 1'b1;
          st_q <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end
endmodule

//--- fifo_partition_checker.sv
module fifo_partition_checker
  import cfg_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // link signals
  input wire logic req,
  input wire logic wr,
  input wire logic [1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic seen_rd_q;
  logic rd_cfg_q;
  wire take = req && !ack;
  wire rd_cfg_d = take && !wr && (addr == LNK_HARDWARE_CONFIGURATION);
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_rd_q <= 1'b0;
      rd_cfg_q <= 1'b0;
    end else begin
      seen_rd_q <= seen_rd_q | (take & ~wr);
      rd_cfg_q <= rd_cfg_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  AST_ACK_PULSE: assert property (ack |=> !ack) else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (ack |-> $past(take)) else $error("ack without request");
  AST_ACK_PROMPT: assert property (take |=> ack) else $error("ack late");
  AST_REQ_DROP: assert property (ack |=> !req) else $error("req held after ack");
  AST_RDATA_HOLD: assert property (!ack |-> $stable(rdata)) else $error("rdata moved");
  AST_READ_FIRST: assert property (req && wr |-> seen_rd_q) else $error("write before read");
  AST_CFG_ZEROS: assert property (ack && rd_cfg_q |-> rdata[31:20] == 12'h000 && rdata[15:4] == 12'h000)
    else $error("config read shows stray bits");
  AST_SIZE_LEGAL: assert property (ack && rd_cfg_q |-> rdata[19:16] inside {[TX_SZ_MIN:TX_SZ_MAX]})
    else $error("size code out of range");
  AST_TO_IDLE: assert property (ack && rd_cfg_q && rdata[1] |-> !rdata[0])
    else $error("timeout with reset still running");
endmodule

//--- fifo_partition_and_soft_reset_tb_top.sv
module fifo_partition_and_soft_reset_tb_top
  import cfg_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_b, mdio_in, phy_rx_clk, phy_tx_clk, pm_wake, phy_run, phy_awake, fifos_idle;
  logic tx_err_evt, rx_err_evt, txf_valid, txf_last, txf_ready, mac_tx_ready, mac_rx_valid, mac_rx_last;
  logic ext_mii_enable, int_phy_enable, mac_reset, system_control_status_regs_reset, tx_error_flag, rx_error_flag;
  logic mac_tx_valid, mac_tx_last, rxf_valid, rxf_last, rxf_full, avs_read, avs_write, avs_waitrequest;
  logic [31:0] txf_data, mac_tx_data, mac_rx_data, rxf_data, avs_writedata, avs_readdata, rd;
  logic [14:0] tx_data_bytes, rx_data_bytes, rx_status_bytes;
  logic [12:0] rxf_used_words;
  logic [15:0] drop_count;
  logic [1:0] avs_address, pdiv;
  logic [32:0] txq[$], rxq[$];
  int miscompares, tests_run, cyc;
  cfg_link_if lnk ();
  fifo_partition_dev #(.TX_STAGE_WORDS(512), .RX_STAGE_WORDS(8)) fifo_partition_dev_i (.core_clk(core_clk),
    .rst_b(rst_b), .lnk(lnk), .mdio_in(mdio_in), .phy_rx_clk(phy_rx_clk), .phy_tx_clk(phy_tx_clk),
    .pm_wake(pm_wake), .ext_mii_enable(ext_mii_enable), .int_phy_enable(int_phy_enable), .mac_reset(mac_reset),
    .system_control_status_regs_reset(system_control_status_regs_reset), .tx_data_bytes(tx_data_bytes), .rx_data_bytes(rx_data_bytes),
    .rx_status_bytes(rx_status_bytes), .tx_err_evt(tx_err_evt), .rx_err_evt(rx_err_evt),
    .tx_error_flag(tx_error_flag), .rx_error_flag(rx_error_flag), .txf_valid(txf_valid), .txf_data(txf_data),
    .txf_last(txf_last), .txf_ready(txf_ready), .mac_tx_valid(mac_tx_valid), .mac_tx_data(mac_tx_data),
    .mac_tx_last(mac_tx_last), .mac_tx_ready(mac_tx_ready), .mac_rx_valid(mac_rx_valid),
    .mac_rx_data(mac_rx_data), .mac_rx_last(mac_rx_last), .rxf_valid(rxf_valid), .rxf_data(rxf_data),
    .rxf_last(rxf_last), .rxf_used_words(rxf_used_words), .rxf_full(rxf_full), .drop_count(drop_count));
  cfg_host_ctl cfg_host_ctl_i (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .phy_awake(phy_awake), .fifos_idle(fifos_idle), .lnk(lnk));
  fifo_partition_checker fifo_partition_checker_i (.core_clk(core_clk), .rst_b(rst_b), .req(lnk.req),
    .wr(lnk.wr), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // phy clocks stand still while stopped
  always @(posedge core_clk) begin
    pdiv <= pdiv + 2'h1;
    if (phy_run && pdiv == 2'h3) begin
      phy_rx_clk <= ~phy_rx_clk;
      phy_tx_clk <= ~phy_tx_clk;
    end
    if (mac_tx_valid === 1'b1 && mac_tx_ready === 1'b1) txq.push_back({mac_tx_last, mac_tx_data});
    if (rxf_valid === 1'b1 && rxf_full === 1'b0) rxq.push_back({rxf_last, rxf_data});
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      close_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_read <= ~w;
    avs_write <= w;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic t_sizes;
    int r;
    av(1'b0, AVS_HARDWARE_CONFIGURATION, 32'h0);
    chk(rd, 33'h0005_0008);
    for (int s = 2; s <= 14; s++) begin
      r = 16384 - s * 1024;
      av(1'b1, AVS_HARDWARE_CONFIGURATION, 32'((s << 16) | ((s & 1) << 2)));
      repeat (2) @(posedge core_clk);
      chk(33'(tx_data_bytes), 33'(s * 1024 - 512));
      chk(33'(rx_status_bytes), 33'(r / 16));
      chk(33'(rx_data_bytes), 33'(r - r / 16));
      chk(33'({ext_mii_enable, int_phy_enable}), 33'((s & 1) ? 2 : 1));
      av(1'b0, AVS_HARDWARE_CONFIGURATION, 32'h0);
      chk(33'(rd[19:16]), 33'(s));
    end
    // reserved codes 15, 0 and 1 must never reach the device
    for (int s = 0; s < 3; s++) av(1'b1, AVS_HARDWARE_CONFIGURATION, 32'(((s + 15) % 16) << 16));
    av(1'b0, AVS_HARDWARE_CONFIGURATION, 32'h0);
    chk(33'(rd[19:16]), 33'he);
    av(1'b0, AVS_STATUS, 32'h0);
    chk(rd, 33'h3);
    rxf_used_words <= 13'd476;
    repeat (3) @(posedge core_clk);
    chk(33'(rxf_full), 33'h1);
    rxf_used_words <= 13'd475;
    repeat (3) @(posedge core_clk);
    chk(33'(rxf_full), 33'h0);
  endtask
  task automatic t_lock;
    pm_wake <= 1'b1;
    @(posedge core_clk);
    pm_wake <= 1'b0;
    av(1'b1, AVS_HARDWARE_CONFIGURATION, 32'h0007_0004);
    av(1'b0, AVS_HARDWARE_CONFIGURATION, 32'h0);
    chk(33'(rd[19:16]), 33'he);
    av(1'b1, AVS_HARDWARE_CONFIGURATION, 32'h0007_0004);
    av(1'b0, AVS_HARDWARE_CONFIGURATION, 32'h0);
    chk(33'(rd[19:16]), 33'h7);
    // busy fifos block a size change, a sleeping phy blocks a reset
    fifos_idle <= 1'b0;
    av(1'b1, AVS_HARDWARE_CONFIGURATION, 32'h0009_0004);
    fifos_idle <= 1'b1;
    phy_awake <= 1'b0;
    av(1'b1, AVS_HARDWARE_CONFIGURATION, 32'h0007_0005);
    phy_awake <= 1'b1;
    av(1'b0, AVS_HARDWARE_CONFIGURATION, 32'h0);
    chk(rd, 33'h0007_000c);
    av(1'b0, AVS_STATUS, 32'h0);
    chk(rd, 33'h3);
  endtask
  task automatic t_sw_reset_trigger;
    int n;
    tx_err_evt <= 1'b1;
    rx_err_evt <= 1'b1;
    @(posedge core_clk);
    tx_err_evt <= 1'b0;
    rx_err_evt <= 1'b0;
    av(1'b1, AVS_HARDWARE_CONFIGURATION, 32'h0007_0005);
    av(1'b0, AVS_HARDWARE_CONFIGURATION, 32'h0);
    chk(33'(rd[0]), 33'h1);
    repeat (1300) @(posedge core_clk);
    av(1'b0, AVS_HARDWARE_CONFIGURATION, 32'h0);
    chk(rd, 33'h0007_000e);
    chk(33'({tx_error_flag, rx_error_flag}), 33'h3);
    // clocks back first, then retry
    phy_run <= 1'b1;
    repeat (40) @(posedge core_clk);
    av(1'b1, AVS_HARDWARE_CONFIGURATION, 32'h0007_0005);
    n = 0;
    while (mac_reset !== 1'b1 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk(33'({mac_reset, system_control_status_regs_reset}), 33'h3);
    repeat (2) @(posedge core_clk);
    chk(33'({tx_error_flag, rx_error_flag}), 33'h0);
    av(1'b0, AVS_HARDWARE_CONFIGURATION, 32'h0);
    chk(rd, 33'h0007_000c);
  endtask
  task automatic t_stage;
    mac_tx_ready <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      txf_valid <= 1'b1;
      txf_data <= 32'(i + 16);
      txf_last <= (i == 2);
      do @(posedge core_clk); while (txf_ready !== 1'b1);
    end
    txf_valid <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk(33'(txq.size()), 33'h0);
    mac_tx_ready <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk(33'(txq.size()), 33'h3);
    for (int i = 0; i < 3; i++) chk(txq[i], {(i == 2), 32'(i + 16)});
    // rx fifo full: frame 0 staged, staging overruns in frame 1, frame 2 lost
    rxf_used_words <= 13'd2160;
    rxq.delete();
    repeat (3) @(posedge core_clk);
    for (int f = 0; f < 3; f++) begin
      for (int i = 0; i < 8; i++) begin
        mac_rx_valid <= 1'b1;
        mac_rx_data <= 32'(f * 16 + i);
        mac_rx_last <= (i == 7);
        @(posedge core_clk);
      end
    end
    mac_rx_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(33'(drop_count), 33'h2);
    av(1'b0, AVS_DROP_CNT, 32'h0);
    chk(33'(rd[15:0]), 33'h2);
    chk(33'(rxq.size()), 33'h0);
    rxf_used_words <= 13'd0;
    repeat (30) @(posedge core_clk);
    for (int i = 0; i < 8; i++) chk(rxq[i], {(i == 7), 32'(i)});
  endtask
  task automatic t_strap;
    // second hard reset with the strap pulled low
    mdio_in <= 1'b0;
    rst_b <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    av(1'b0, AVS_HARDWARE_CONFIGURATION, 32'h0);
    chk(rd, 33'h0005_0000);
    chk(33'({ext_mii_enable, int_phy_enable}), 33'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, phy_rx_clk, phy_tx_clk, pm_wake, phy_run, tx_err_evt, rx_err_evt} = 7'h0;
    {txf_valid, txf_last, mac_rx_valid, mac_rx_last, avs_read, avs_write} = 6'h0;
    {mdio_in, phy_awake, fifos_idle, mac_tx_ready} = 4'hf;
    {txf_data, mac_rx_data, avs_writedata, avs_address, pdiv} = 100'h0;
    rxf_used_words = 13'd0;
    miscompares = 0;
    tests_run = 0;
    cyc = 0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    t_sizes;
    t_lock;
    t_sw_reset_trigger;
    t_stage;
    t_strap;
    close_out;
  end
endmodule
